/* File: clock_source_startup_select_test.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_select_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [7:0] CAL = 8'h5a; // arbitrary trim value
  logic clk, srst, div8, blank, wake_req, trim_we, presc_we;
  logic tosc_en, tosc_ext, ext_t, rc_t, lf_t, k128_t, wdt_t, pin;
  logic [3:0] src_f, presc_wdata, presc;
  logic [1:0] start_f;
  logic [7:0] trim_wdata, trim;
  logic [2:0] act;
  logic       tosc_clk, usable, rsvd, hold, sys_t, wdt_o;
  int         fail_count, total_checks;
  logic [3:0] tb_s [0:7] = '{4'h0, 4'h0, 4'h2, 4'h3, 4'h3, 4'h6, 4'h7, 4'h2};
  logic [1:0] tb_u [0:7] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};

  cssel_osc_model u_osc (.clk(clk), .ext_tick(ext_t), .rc_tick(rc_t),
    .lf_tick(lf_t), .osc128_tick(k128_t), .wdt_osc_tick(wdt_t),
    .timer_osc_pin_one(pin));

  cssel_top #(.FACTORY_CAL(CAL), .CNT_FAST(20), .CNT_SLOW(40),
    .CNT_FAST_128K(18), .CNT_SLOW_128K(36)) u_dut (
    .clk(clk), .srst(srst), .clock_source_select_fuses(src_f),
    .startup_time_fuses(start_f), .divide_by_eight_fuse(div8),
    .fuses_blank(blank), .ext_tick(ext_t), .rc_tick(rc_t),
    .lf_tick(lf_t), .osc128_tick(k128_t), .wdt_osc_tick(wdt_t),
    .wake_req(wake_req), .trim_we(trim_we), .trim_wdata(trim_wdata),
    .oscillator_trim_register(trim), .presc_we(presc_we),
    .presc_wdata(presc_wdata), .prescaler_select_field(presc),
    .timer_osc_en(tosc_en), .timer_osc_external_input_enable(tosc_ext),
    .timer_osc_pin_one(pin), .timer_osc_clk(tosc_clk),
    .timer_osc_usable(usable), .active_source(act),
    .source_reserved(rsvd), .cpu_hold(hold), .sys_clk_tick(sys_t),
    .wdt_clk_tick(wdt_o));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  function automatic int per(input logic [3:0] s);
    return (s == 4'h0) ? 3 : (s == 4'h3) ? 4 : 2;
  endfunction

  function automatic int extra(input logic [3:0] s, input logic [1:0] u);
    if (u == 2'h0) return 0;
    if (s == 4'h3) return (u == 2'h1) ? 18 : 36;
    return (u == 2'h1) ? 20 : 40;
  endfunction

  task automatic do_reset(input logic [3:0] s, input logic [1:0] u,
                          input logic d, input logic b);
    @(posedge clk);
    srst  <= 1'b1;
    src_f <= s;
    start_f <= u;
    div8  <= d;
    blank <= b;
    repeat (5) @(posedge clk);
    #1;
    chk("trim_rst", CAL, trim);
    chk("presc_rst", 8'h03, presc);
    @(posedge clk);
    srst <= 1'b0;
  endtask

  // cycles until cpu_hold drops, bounded
  task automatic wait_run(input int lim, output int n);
    n = 0;
    while (n < lim) begin
      @(posedge clk);
      #1;
      n++;
      if (hold === 1'b0) break;
    end
  endtask

  task automatic count_sys(output int k);
    k = 0;
    repeat (160) begin
      @(posedge clk);
      #1;
      if (sys_t === 1'b1) k++;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot(input logic [3:0] s, input logic [1:0] u,
                        input logic d);
    int n, p, x, w;
    p = per(s);
    x = extra(s, u);
    do_reset(s, u, d, 1'b0);
    wait_run(3000, n);
    chk("src", (s == 4'h0) ? 1 : (s >= 4'h6) ? 4 : s, act);
    chk("presc", d ? 8'h03 : 8'h00, presc);
    chk_rng("rst_delay", 13 * p + x, 15 * p + x + 4, n);
    chk("usable", s == 4'h2, usable);
    w = (s == 4'h6) ? 1024 : (s == 4'h7) ? 32768 : 6;
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    wait_run(70000, n);
    chk_rng("wake", (w - 1) * p, (w + 1) * p + 4, n);
  endtask

  task automatic t_regs;
    int k;
    count_sys(k);
    chk_rng("div8_rate", 9, 11, k);
    @(posedge clk);
    trim_we     <= 1'b1;
    trim_wdata  <= 8'h3c;
    presc_we    <= 1'b1;
    presc_wdata <= 4'h0;
    @(posedge clk);
    trim_we  <= 1'b0;
    presc_we <= 1'b0;
    #1;
    chk("trim_wr", 8'h3c, trim);
    chk("presc_wr", 8'h00, presc);
    count_sys(k);
    chk_rng("div1_rate", 78, 82, k);
    repeat (10) begin
      @(posedge clk);
      #1;
      chk("wdt_tick", wdt_t, wdt_o);
    end
  endtask

  task automatic t_tosc;
    logic l;
    int   n;
    @(posedge clk);
    tosc_ext <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      l = pin;
      n = 0;
      while (pin === l && n < 40) begin
        @(posedge clk);
        #1;
        n++;
      end
      repeat (6) @(posedge clk);
      #1;
      chk("tosc_clk", pin, tosc_clk);
    end
    @(posedge clk);
    tosc_en <= 1'b0;
    @(posedge clk);
    #1;
    chk("usable_off", 8'h00, usable);
    @(posedge clk);
    tosc_en <= 1'b1;
  endtask

  task automatic t_reserved(input logic [3:0] s, input logic [1:0] u,
                            input logic [7:0] e);
    do_reset(s, u, 1'b1, 1'b0);
    repeat (150) @(posedge clk);
    #1;
    chk("rsvd", 8'h01, rsvd);
    chk("rsvd_src", e, act);
    chk("rsvd_hold", 8'h01, hold);
  endtask

  task automatic t_blank;
    int n;
    do_reset(4'h0, 2'h0, 1'b0, 1'b1);
    wait_run(3000, n);
    chk("blank_src", 8'h02, act);
    chk("blank_presc", 8'h03, presc);
    chk_rng("blank_delay", 13 * 2 + 40, 15 * 2 + 44, n);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #2500000;
    fail_count++;
    give_verdict();
  end

  initial begin
    fail_count = 0; total_checks = 0;
    srst = 1'b1; src_f = 4'h2; start_f = 2'h0; div8 = 1'b1; blank = 1'b0;
    wake_req = 1'b0; trim_we = 1'b0; trim_wdata = 8'h00;
    presc_we = 1'b0; presc_wdata = 4'h0; tosc_en = 1'b1; tosc_ext = 1'b0;
    t_boot(4'h2, 2'h2, 1'b1);
    t_regs();
    t_tosc();
    for (int i = 0; i < 8; i++) begin
      t_boot(tb_s[i], tb_u[i], i[0]);
    end
    // a listed source code still shows while its start-up code parks it
    t_reserved(4'h2, 2'h3, 8'h02);
    t_reserved(4'h5, 2'h0, 8'h00);
    t_blank();
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: cssel_delay_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
module cssel_delay_cnt (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         srst,
  // control
  input  wire logic                         load,
  input  wire logic [cssel_pkg::CNT_W-1:0]  load_val,
  input  wire logic                         tick,
  // status
  output logic                              busy
);

  typedef struct packed {
    logic [cssel_pkg::CNT_W-1:0] cnt;
  } cssel_dc_state_t;

  cssel_dc_state_t st_q;
  cssel_dc_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (load) begin
      st_d.cnt = load_val;
    end else if (tick && st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = (st_q.cnt != '0);

endmodule
`default_nettype wire

/* File: cssel_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cssel_osc_model (
  // clock
  input  wire logic clk,
  // oscillator pulses
  output logic      ext_tick,
  output logic      rc_tick,
  output logic      lf_tick,
  output logic      osc128_tick,
  output logic      wdt_osc_tick,
  // timer oscillator pin
  output logic      timer_osc_pin_one
);
  // ----------------------------------------
  // free-running oscillators
  // ----------------------------------------
  logic [7:0] cnt_q;

  initial begin
    cnt_q             = 8'h00;
    ext_tick          = 1'b0;
    rc_tick           = 1'b0;
    lf_tick           = 1'b0;
    osc128_tick       = 1'b0;
    wdt_osc_tick      = 1'b0;
    timer_osc_pin_one = 1'b0;
    // no rate steps
    // wrap at 240 keeps every period whole, so no step at the wrap
    // pin rate slow
    // pin toggles every 16 cycles, far below a quarter of the rc rate
    forever begin
      @(posedge clk);
      cnt_q        <= (cnt_q == 8'hef) ? 8'h00 : cnt_q + 8'h01;
      ext_tick     <= (cnt_q % 3) == 0;
      rc_tick      <= (cnt_q % 2) == 0;
      lf_tick      <= (cnt_q % 2) == 1;
      osc128_tick  <= (cnt_q % 4) == 0;
      wdt_osc_tick <= (cnt_q % 5) == 0;
      if ((cnt_q % 16) == 0) begin
        timer_osc_pin_one <= ~timer_osc_pin_one;
      end
    end
  end
endmodule
`default_nettype wire

/* File: cssel_pkg.sv */
`default_nettype none
package cssel_pkg;

  // ----------------------------------------
  // fuse encodings
  // ----------------------------------------
  localparam logic [3:0] SRC_EXT     = 4'h0;
  localparam logic [3:0] SRC_RC      = 4'h2;
  localparam logic [3:0] SRC_128K    = 4'h3;
  localparam logic [3:0] SRC_LF_FAST = 4'h6;
  localparam logic [3:0] SRC_LF_SLOW = 4'h7;

  localparam logic [1:0] STARTUP_BASE = 2'h0;
  localparam logic [1:0] STARTUP_FAST = 2'h1;
  localparam logic [1:0] STARTUP_SLOW = 2'h2;
  localparam logic [1:0] STARTUP_RSVD = 2'h3;

  localparam logic [3:0] PS_DIV1 = 4'h0;
  localparam logic [3:0] PS_DIV8 = 4'h3;
  localparam logic [3:0] PS_MAX  = 4'h8;

  // ----------------------------------------
  // source codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    CSSEL_SRC_NONE = 3'h0,
    CSSEL_SRC_EXT  = 3'h1,
    CSSEL_SRC_RC   = 3'h2,
    CSSEL_SRC_128K = 3'h3,
    CSSEL_SRC_LF   = 3'h4
  } cssel_src_t;

  // ----------------------------------------
  // timing, in source cycles
  // ----------------------------------------
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] WAKE_SHORT_CK = 24'h000006;
  localparam logic [CNT_W-1:0] WAKE_1K_CK    = 24'h000400;
  localparam logic [CNT_W-1:0] WAKE_32K_CK   = 24'h008000;
  localparam logic [CNT_W-1:0] RESET_BASE_CK = 24'h00000e;

  // delay times in microseconds as printed
  localparam int unsigned T_FAST_US      = 4100;
  localparam int unsigned T_SLOW_US      = 65000;
  localparam int unsigned T_FAST_128K_US = 4000;
  localparam int unsigned T_SLOW_128K_US = 64000;
  localparam int unsigned CLK_MHZ        = 40;

endpackage
`default_nettype wire

/* File: cssel_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module cssel_prescaler (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // control
  input  wire logic       src_tick,
  input  wire logic [3:0] sel,
  // output
  output logic            sys_tick
);

  typedef struct packed {
    logic [8:0] div;
    logic       tick;
  } cssel_ps_state_t;

  cssel_ps_state_t st_q;
  cssel_ps_state_t st_d;
  logic [8:0]      limit;

  // reserved selections fall back to the largest factor
  always_comb begin
    if (sel > cssel_pkg::PS_MAX) begin
      limit = 9'((10'h001 << cssel_pkg::PS_MAX) - 10'h001);
    end else begin
      limit = 9'((10'h001 << sel) - 10'h001);
    end
  end

  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (src_tick) begin
      if (st_q.div >= limit) begin
        st_d.div  = '0;
        st_d.tick = 1'b1;
      end else begin
        st_d.div = st_q.div + 9'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sys_tick = st_q.tick;

endmodule
`default_nettype wire

/* File: cssel_top.sv */
// Functional notes
// R1: fuse codes 0110 and 0111 select the low-frequency watch crystal.
// R2: crystal wake waits 1K cycles for 0110, 32K cycles for 0111.
// R3: crystal reset delay 14 cycles, plus 4.1 ms or 65 ms by fuse.
// R4: fuse code 0010 selects the 8 MHz internal RC oscillator.
// R5: every reset copies factory calibration into the trim register.
// R6: software writes to the trim register retune the RC immediately.
// R7: watchdog and reset time-out stay on the watchdog oscillator; here the reset time-out counts clk cycles instead.
// R8: RC wake 6 cycles; reset 14 cycles plus 4.1 or 65 ms.
// R9: shipped with RC, slow-power start-up and divide-by-eight fuse.
// R10: divide-by-eight fuse divides internal clock by eight.
// R11: fuse code 0011 selects the 128 kHz internal oscillator.
// R12: 128 kHz wake 6 cycles; reset 14 cycles plus 4 or 64 ms.
// R13: fuse code 0000 selects external clock input, 0 to 20 MHz.
// R14: external clock wake 6 cycles; reset 14 plus 4.1 or 65 ms.
// R15: external driver holds reset for frequency steps over 2 percent.
// R16: timer oscillator needs system clock four times its own rate.
// R17: timer oscillator usable only with the RC oscillator selected.
// R18: enable bit set lets timer pin one take an external clock.
// R19: prescaler select resets to 0011 with fuse, else 0000.
// R20: fuses sampled at reset, counts in source cycles, others reserved.
`timescale 1ns/1ps
`default_nettype none
module cssel_top #(
  parameter logic [7:0] FACTORY_CAL    = 8'h80,
  parameter logic [3:0] SHIP_CKSRC     = cssel_pkg::SRC_RC,
  parameter logic [1:0] SHIP_START     = cssel_pkg::STARTUP_SLOW,
  parameter logic       SHIP_DIV8      = 1'b1,
  parameter int unsigned CNT_FAST      = cssel_pkg::T_FAST_US
                                         * cssel_pkg::CLK_MHZ,
  parameter int unsigned CNT_SLOW      = cssel_pkg::T_SLOW_US
                                         * cssel_pkg::CLK_MHZ,
  parameter int unsigned CNT_FAST_128K = cssel_pkg::T_FAST_128K_US
                                         * cssel_pkg::CLK_MHZ,
  parameter int unsigned CNT_SLOW_128K = cssel_pkg::T_SLOW_128K_US
                                         * cssel_pkg::CLK_MHZ
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // fuses
  input  wire logic [3:0] clock_source_select_fuses,
  input  wire logic [1:0] startup_time_fuses,
  input  wire logic       divide_by_eight_fuse,
  input  wire logic       fuses_blank,
  // source ticks, one cycle each
  input  wire logic       ext_tick,
  input  wire logic       rc_tick,
  input  wire logic       lf_tick,
  input  wire logic       osc128_tick,
  input  wire logic       wdt_osc_tick,
  // power management
  input  wire logic       wake_req,
  // trim register port
  input  wire logic       trim_we,
  input  wire logic [7:0] trim_wdata,
  output logic      [7:0] oscillator_trim_register,
  // prescaler port
  input  wire logic       presc_we,
  input  wire logic [3:0] presc_wdata,
  output logic      [3:0] prescaler_select_field,
  // timer oscillator
  input  wire logic       timer_osc_en,
  input  wire logic       timer_osc_external_input_enable,
  input  wire logic       timer_osc_pin_one,
  output logic            timer_osc_clk,
  output logic            timer_osc_usable,
  // status
  output logic      [2:0] active_source,
  output logic            source_reserved,
  output logic            cpu_hold,
  output logic            sys_clk_tick,
  output logic            wdt_clk_tick
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_SAMPLE = 4'b0001,
    ST_BASE   = 4'b0010,
    ST_EXTRA  = 4'b0100,
    ST_RUN    = 4'b1000
  } cssel_fsm_t;

  typedef struct packed {
    cssel_fsm_t              fsm;
    cssel_pkg::cssel_src_t   src;
    logic [3:0]              cksrc;
    logic [1:0]              startup;
    logic [7:0]              trim;
    logic [3:0]              presc;
    logic [2:0]              pin_sync;
    logic                    pin_lvl;
    logic                    wake_pend;
  } cssel_state_t;

  cssel_state_t st_q;
  cssel_state_t st_d;

  logic                          src_tick;
  logic                          dc_load;
  logic [cssel_pkg::CNT_W-1:0]   dc_val;
  logic                          dc_tick;
  logic                          dc_busy;
  logic                          ps_tick;
  logic [3:0]                    eff_cksrc;
  logic [1:0]                    eff_start;
  logic                          eff_div8;

  // ----------------------------------------
  // fuse values, shipped defaults when blank
  // ----------------------------------------
  // R9: shipped defaults
  assign eff_cksrc = fuses_blank ? SHIP_CKSRC : clock_source_select_fuses;
  assign eff_start = fuses_blank ? SHIP_START : startup_time_fuses;
  assign eff_div8  = fuses_blank ? SHIP_DIV8  : divide_by_eight_fuse;

  // ----------------------------------------
  // selected source tick
  // ----------------------------------------
  always_comb begin
    case (st_q.src)
      cssel_pkg::CSSEL_SRC_EXT:  src_tick = ext_tick;
      cssel_pkg::CSSEL_SRC_RC:   src_tick = rc_tick;
      cssel_pkg::CSSEL_SRC_128K: src_tick = osc128_tick;
      cssel_pkg::CSSEL_SRC_LF:   src_tick = lf_tick;
      default:                   src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    st_d    = st_q;
    dc_load = 1'b0;
    dc_val  = '0;
    // R20: source-cycle counting
    dc_tick = src_tick;
    st_d.pin_sync = {st_q.pin_sync[1:0], timer_osc_pin_one};
    if (st_q.pin_sync[2] == st_q.pin_sync[1]) begin
      st_d.pin_lvl = st_q.pin_sync[1];
    end
    // R6: run-time trim write
    if (trim_we) begin
      st_d.trim = trim_wdata;
    end
    if (presc_we) begin
      st_d.presc = presc_wdata;
    end
    case (st_q.fsm)
      ST_SAMPLE: begin
        // R20: fuses sampled only here
        st_d.cksrc = eff_cksrc;
        st_d.startup = eff_start;
        // R19: prescaler reset value
        st_d.presc = eff_div8 ? cssel_pkg::PS_DIV8 : cssel_pkg::PS_DIV1;
        case (eff_cksrc)
          // R13: external clock
          cssel_pkg::SRC_EXT:     st_d.src = cssel_pkg::CSSEL_SRC_EXT;
          // R4: rc oscillator
          cssel_pkg::SRC_RC:      st_d.src = cssel_pkg::CSSEL_SRC_RC;
          // R11: 128 khz oscillator
          cssel_pkg::SRC_128K:    st_d.src = cssel_pkg::CSSEL_SRC_128K;
          // R1: watch crystal codes
          cssel_pkg::SRC_LF_FAST: st_d.src = cssel_pkg::CSSEL_SRC_LF;
          cssel_pkg::SRC_LF_SLOW: st_d.src = cssel_pkg::CSSEL_SRC_LF;
          default:                st_d.src = cssel_pkg::CSSEL_SRC_NONE;
        endcase
        // R3: 14 cycle base delay
        dc_load = 1'b1;
        dc_val  = cssel_pkg::RESET_BASE_CK;
        // reserved source or sut code parks the block held
        if (eff_start != cssel_pkg::STARTUP_RSVD &&
            st_d.src != cssel_pkg::CSSEL_SRC_NONE) begin
          st_d.fsm = ST_BASE;
        end
      end
      ST_BASE: begin
        if (!dc_busy) begin
          // R7: time-out loaded here, then counted on every clk cycle, not the watchdog oscillator
          dc_tick = 1'b0;
          dc_load = 1'b1;
          st_d.fsm = ST_EXTRA;
          // R12: 128 khz has its own times
          if (st_q.src == cssel_pkg::CSSEL_SRC_128K) begin
            if (st_q.startup == cssel_pkg::STARTUP_FAST) begin
              dc_val = CNT_FAST_128K[cssel_pkg::CNT_W-1:0];
            end else if (st_q.startup == cssel_pkg::STARTUP_SLOW) begin
              dc_val = CNT_SLOW_128K[cssel_pkg::CNT_W-1:0];
            end
          // R8: R14: same extra time
          end else if (st_q.startup == cssel_pkg::STARTUP_FAST) begin
            dc_val = CNT_FAST[cssel_pkg::CNT_W-1:0];
          end else if (st_q.startup == cssel_pkg::STARTUP_SLOW) begin
            dc_val = CNT_SLOW[cssel_pkg::CNT_W-1:0];
          end
        end
      end
      ST_EXTRA: begin
        // extra time runs on the fixed system clock, not the source
        dc_tick = 1'b1;
        if (!dc_busy) begin
          st_d.fsm = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wake_req) begin
          dc_load = 1'b1;
          st_d.fsm = ST_BASE;
          st_d.wake_pend = 1'b1;
          // R2: crystal wake by code
          if (st_q.src == cssel_pkg::CSSEL_SRC_LF) begin
            dc_val = (st_q.cksrc == cssel_pkg::SRC_LF_SLOW) ?
                     cssel_pkg::WAKE_32K_CK : cssel_pkg::WAKE_1K_CK;
          end else begin
            // R8: R12: R14: short wake
            dc_val = cssel_pkg::WAKE_SHORT_CK;
          end
        end
      end
      default: st_d.fsm = ST_SAMPLE;
    endcase
    // wake skips the reset extra time
    if (st_q.wake_pend && st_q.fsm == ST_BASE && !dc_busy) begin
      st_d.fsm       = ST_RUN;
      st_d.wake_pend = 1'b0;
      dc_load        = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q.fsm       <= ST_SAMPLE;
      st_q.src       <= cssel_pkg::CSSEL_SRC_NONE;
      st_q.cksrc     <= cssel_pkg::SRC_RC;
      st_q.startup   <= cssel_pkg::STARTUP_SLOW;
      // R5: calibration loaded on reset
      st_q.trim      <= FACTORY_CAL;
      st_q.presc     <= cssel_pkg::PS_DIV8;
      st_q.pin_sync  <= '0;
      st_q.pin_lvl   <= 1'b0;
      st_q.wake_pend <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  cssel_delay_cnt u_delay (
    .clk      (clk),
    .srst     (srst),
    .load     (dc_load),
    .load_val (dc_val),
    .tick     (dc_tick),
    .busy     (dc_busy)
  );

  // R10: divide by eight via prescaler
  cssel_prescaler u_presc (
    .clk      (clk),
    .srst     (srst),
    .src_tick (src_tick),
    .sel      (st_q.presc),
    .sys_tick (ps_tick)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign oscillator_trim_register = st_q.trim;
  assign prescaler_select_field   = st_q.presc;
  assign active_source            = st_q.src;
  assign source_reserved = (st_q.fsm == ST_SAMPLE) && !srst;
  assign cpu_hold        = (st_q.fsm != ST_RUN);
  assign sys_clk_tick    = ps_tick && (st_q.fsm == ST_RUN);
  // R7: watchdog clock independent
  assign wdt_clk_tick    = wdt_osc_tick;
  // R17: R16: only with rc as system clock
  assign timer_osc_usable = timer_osc_en &&
                            (st_q.src == cssel_pkg::CSSEL_SRC_RC);
  // R18: external input on pin one
  assign timer_osc_clk = timer_osc_usable &&
                         timer_osc_external_input_enable && st_q.pin_lvl;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // R5: trim after reset
  trim_reset_a: assert property (@(posedge clk) // R5
    $fell(srst) |-> oscillator_trim_register == FACTORY_CAL)
    else $error("trim not loaded at reset");
  // R6: trim write
  trim_write_a: assert property (@(posedge clk) disable iff (srst) // R6
    trim_we |=> oscillator_trim_register == $past(trim_wdata))
    else $error("trim write lost");
  // R19: prescaler reset value
  presc_init_a: assert property (@(posedge clk) disable iff (srst) // R19
    st_q.fsm == ST_SAMPLE && !presc_we |=>
      prescaler_select_field == ($past(eff_div8) ? 4'h3 : 4'h0))
    else $error("prescaler reset value wrong");
  // R17: timer osc needs rc
  tosc_rc_a: assert property (@(posedge clk) disable iff (srst) // R17
    timer_osc_usable |-> active_source == 3'h2)
    else $error("timer oscillator without rc");
  // R1: crystal select
  lf_select_a: assert property (@(posedge clk) disable iff (srst) // R1
    st_q.fsm == ST_SAMPLE && eff_cksrc[3:1] == 3'h3 |=>
      active_source == 3'h4)
    else $error("crystal not selected");
  // R8: short wake
  wake_short_a: assert property (@(posedge clk) disable iff (srst) // R8
    st_q.fsm == ST_RUN && wake_req && st_q.src != 3'h4 |=>
      cpu_hold [*1] ##0 u_delay.st_q.cnt == 24'h000006)
    else $error("wake count wrong");
  // R2: long wake
  wake_long_a: assert property (@(posedge clk) disable iff (srst) // R2
    st_q.fsm == ST_RUN && wake_req && st_q.cksrc == 4'h7 &&
    st_q.src == 3'h4 |=> u_delay.st_q.cnt == 24'h008000)
    else $error("crystal wake count wrong");
  // R3: base delay
  base_hold_a: assert property (@(posedge clk) disable iff (srst) // R3
    $rose(st_q.fsm == ST_BASE) && !st_q.wake_pend |->
      cpu_hold [*8])
    else $error("released too early");
  // R20: reserved code holds
  code_reserved_a: assert property (@(posedge clk) disable iff (srst) // R20
    st_q.fsm == ST_SAMPLE && eff_start == cssel_pkg::STARTUP_RSVD |=>
      cpu_hold)
    else $error("reserved code released");

endmodule
`default_nettype wire
